// ---- pac_originate.sv ----
/*
 Controller that originates a call through a modem's parallel calling circuits.
 Software orders a call, feeds digits and hangs up through a small register port;
 the controller keeps the terminal side of the call handshake on the modem pins.
 Assumes modem pins are asynchronous to ref_clk and are level signals.
*/
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - Check readiness, then raise call request
// RULE2 - Terminal ready raised by end strobe release; the controller raises it together with call request at call start
// RULE3 - Request to send raised before set ready
// RULE4 - Modem flags line occupied after off hook
// RULE5 - Modem requests digit after dial tone
// RULE6 - Set digit lines before raising strobe
// RULE7 - Modem dials, then drops digit request
// RULE8 - Drop strobe after digit request falls
// RULE9 - Handshake repeats per digit, then once more
// RULE10 - Final request answered with end code
// RULE11 - Modem acknowledges end code, sends calling tone
// RULE12 - Modem abandons after selectable no-answer timeout
// RULE13 - Drop call request when abandon seen
// RULE14 - Answer tone leaves receive circuits idle
// RULE15 - Modem passes line control to terminal ready
// RULE16 - Optional calling response after long answer
// RULE17 - Set ready follows silent gap after answer
// RULE18 - Sending start-up gives ready for sending
// RULE19 - Receiving start-up gives signal detect
// RULE20 - Duplex start-up gives both indications
// RULE21 - After distant connected call request may drop
// RULE22 - Disconnect drops call request and terminal ready
// RULE23 - Digit lines steady while strobe is high
// RULE24 - Modem waits for strobe release to re-request
// RULE25 - Strobe held until digit request falls
// RULE26 - Calling tone bursts with silent gaps
// RULE27 - Abandon held until call request drops
module pac_originate
  import pac_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Modem pins, terminal outputs
  output logic call_request,
  output logic [3:0] digit_lines,
  output logic digit_present_strobe,
  output logic data_terminal_ready_line,
  output logic request_to_send_line,
  // Modem pins, modem outputs
  input wire logic power_indication,
  input wire logic line_occupied,
  input wire logic next_digit_request,
  input wire logic abandon_call,
  input wire logic distant_connected,
  input wire logic data_set_ready_line,
  input wire logic ready_for_sending_line,
  input wire logic received_line_signal_detect
);
  typedef enum logic [6:0] {
    PAC_IDLE = 7'h01,
    PAC_WAIT_REQ = 7'h02,
    PAC_SETUP = 7'h04,
    PAC_STROBE = 7'h08,
    PAC_CALLING = 7'h10,
    PAC_ONLINE = 7'h20,
    PAC_RELEASE = 7'h40
  } pac_state_e;

  typedef struct packed {
    pac_state_e state;
    logic [7:0] timer;
    logic [3:0] digit;
    logic digit_valid;
    logic digit_last;
    logic sent_last;
    logic send_first;
    logic drop_callreq;
    logic connected;
    logic abandoned;
    logic not_ready;
    logic call_req;
    logic [3:0] lines;
    logic strobe;
    logic dtr;
    logic rts;
    logic [31:0] rdata;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] held;
  } pac_s;

  pac_s cur_reg;
  pac_s cur_next;
  logic [7:0] pins_raw;
  logic [7:0] pins;

  // Synchronised pin is trusted only once stages two and three agree
  function automatic logic [7:0] pac_settle(input logic [7:0] s2, input logic [7:0] s3, input logic [7:0] held);
    pac_settle = (s2 & s3) | (held & (s2 | s3));
  endfunction : pac_settle

  assign pins_raw = {received_line_signal_detect, ready_for_sending_line, data_set_ready_line,
                     distant_connected, abandon_call, next_digit_request, line_occupied, power_indication};
  assign pins = cur_reg.held;

  logic p_power, p_occ, p_ndr, p_abandon, p_dist;
  assign p_power = pins[0];
  assign p_occ = pins[1];
  assign p_ndr = pins[2];
  assign p_abandon = pins[3];
  assign p_dist = pins[4];

  always_comb begin
    cur_next = cur_reg;
    cur_next.s1 = pins_raw;
    cur_next.s2 = cur_reg.s1;
    cur_next.s3 = cur_reg.s2;
    cur_next.held = pac_settle(cur_reg.s2, cur_reg.s3, cur_reg.held);
    cur_next.rdata = 32'h0;
    if (cur_reg.timer != 8'h00) begin
      cur_next.timer = cur_reg.timer - 8'h01;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CTRL: cur_next.rdata = {28'h0, cur_reg.drop_callreq, cur_reg.send_first, 2'h0};
        ADDR_STATUS: cur_next.rdata = {17'h0, cur_reg.state, 3'h0, cur_reg.not_ready,
                                       cur_reg.abandoned, cur_reg.connected,
                                       ~cur_reg.digit_valid, cur_reg.state != PAC_IDLE};
        ADDR_DIGIT: cur_next.rdata = {27'h0, cur_reg.digit_last, cur_reg.digit};
        ADDR_LINES: cur_next.rdata = {24'h0, pins};
        default: cur_next.rdata = 32'h0;
      endcase
    end
    if (reg_wr && reg_addr == ADDR_CTRL) begin
      cur_next.send_first = reg_wdata[CTRL_SEND_FIRST];
      cur_next.drop_callreq = reg_wdata[CTRL_DROP_CALLREQ];
    end
    // Digit buffer takes a new digit only when empty
    if (reg_wr && reg_addr == ADDR_DIGIT && !cur_reg.digit_valid) begin
      cur_next.digit = reg_wdata[3:0];
      cur_next.digit_last = reg_wdata[DIGIT_LAST_BIT];
      cur_next.digit_valid = 1'b1;
    end
    unique case (cur_reg.state)
      PAC_IDLE: begin
        if (reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CTRL_START]) begin
          // Readiness check before call request
          if (p_power && !p_occ && !p_ndr && !p_abandon && !p_dist && !cur_reg.call_req) begin // see RULE1
            cur_next.call_req = 1'b1; // see RULE1
            cur_next.dtr = 1'b1; // see RULE2
            cur_next.rts = reg_wdata[CTRL_SEND_FIRST]; // see RULE3
            cur_next.send_first = reg_wdata[CTRL_SEND_FIRST];
            cur_next.sent_last = 1'b0;
            cur_next.connected = 1'b0;
            cur_next.abandoned = 1'b0;
            cur_next.not_ready = 1'b0;
            cur_next.state = PAC_WAIT_REQ;
          end else begin
            cur_next.not_ready = 1'b1;
          end
        end
      end
      PAC_WAIT_REQ: begin
        // Digits wait for both the modem request and software
        if (p_ndr && cur_reg.digit_valid) begin // see RULE9
          cur_next.lines = cur_reg.sent_last ? END_OF_NUMBER_CODE : cur_reg.digit; // see RULE6 see RULE10
          cur_next.timer = SETUP_CNT;
          cur_next.state = PAC_SETUP;
        end else if (p_ndr && cur_reg.sent_last) begin
          cur_next.lines = END_OF_NUMBER_CODE; // see RULE10
          cur_next.timer = SETUP_CNT;
          cur_next.state = PAC_SETUP;
        end
      end
      PAC_SETUP: begin
        if (cur_reg.timer == 8'h00) begin
          cur_next.strobe = 1'b1; // see RULE6
          cur_next.state = PAC_STROBE;
        end
      end
      PAC_STROBE: begin
        // Lines stay frozen; strobe drops when request falls or on abandon or hangup
        if (!p_ndr) begin // see RULE8 see RULE25 see RULE23
          cur_next.strobe = 1'b0;
          if (cur_reg.lines == END_OF_NUMBER_CODE && cur_reg.sent_last) begin
            cur_next.state = PAC_CALLING;
          end else begin
            cur_next.digit_valid = 1'b0;
            cur_next.sent_last = cur_reg.digit_last;
            cur_next.state = PAC_WAIT_REQ;
          end
        end
      end
      PAC_CALLING: begin
        if (p_dist) begin // see RULE21
          cur_next.connected = 1'b1;
          cur_next.state = PAC_ONLINE;
        end
      end
      PAC_ONLINE: begin
        if (cur_reg.drop_callreq) begin
          cur_next.call_req = 1'b0; // see RULE21
        end
      end
      PAC_RELEASE: begin
        // Wait for modem to clear abandon before the next call
        if (!p_abandon) begin
          cur_next.state = PAC_IDLE;
        end
      end
      default: cur_next.state = PAC_IDLE;
    endcase
    // Abandon or hangup ends the call from any active state
    if (cur_reg.state != PAC_IDLE && cur_reg.state != PAC_RELEASE) begin
      if (p_abandon || (reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CTRL_HANGUP])) begin
        cur_next.abandoned = p_abandon;
        cur_next.call_req = 1'b0; // see RULE13 see RULE22
        cur_next.dtr = 1'b0; // see RULE22
        cur_next.rts = 1'b0;
        cur_next.strobe = 1'b0;
        cur_next.digit_valid = 1'b0;
        cur_next.connected = 1'b0;
        cur_next.state = PAC_RELEASE;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cur_reg <= '{state: PAC_IDLE, default: '0};
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign reg_rdata = cur_reg.rdata;
  assign call_request = cur_reg.call_req;
  assign digit_lines = cur_reg.lines;
  assign digit_present_strobe = cur_reg.strobe;
  assign data_terminal_ready_line = cur_reg.dtr;
  assign request_to_send_line = cur_reg.rts;

  a_lines_stable: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE23
    (digit_present_strobe && $past(digit_present_strobe)) |-> digit_lines == $past(digit_lines))
    else $error("digit lines changed under strobe");
  a_strobe_hold: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE25
    ($fell(digit_present_strobe) && cur_reg.state != PAC_RELEASE) |-> !$past(p_ndr))
    else $error("strobe dropped while digit request high");
  a_strobe_setup: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE6
    $rose(digit_present_strobe) |-> $stable(digit_lines) [*1] ##0 $past(cur_reg.state == PAC_SETUP))
    else $error("strobe raised without settled lines");
  a_start_check: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE1
    $rose(call_request) |-> $past(p_power && !p_occ && !p_ndr && !p_abandon && !p_dist))
    else $error("call request raised while modem not ready");
  a_abandon_drop: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE13
    (p_abandon && cur_reg.state != PAC_IDLE) |-> ##1 !call_request)
    else $error("call request kept after abandon");
  a_dtr_early: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE2
    (cur_reg.state == PAC_CALLING) |-> data_terminal_ready_line)
    else $error("terminal ready not up after end of number");
  a_end_code: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE10
    (cur_reg.state == PAC_CALLING && $past(cur_reg.state) == PAC_STROBE) |->
      $past(digit_lines) == END_OF_NUMBER_CODE)
    else $error("number not closed by end code");
  a_disconnect: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE22
    (cur_reg.state == PAC_RELEASE) |-> (!call_request && !data_terminal_ready_line))
    else $error("disconnect left a line up");
  a_rts_before: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE3
    $rose(request_to_send_line) |-> $rose(call_request))
    else $error("request to send raised late");

  // Terminal-side handshake checks
  a_strobe_on_req: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE6
    $rose(digit_present_strobe) |-> $past(p_ndr))
    else $error("strobe raised without digit request");
  a_dtr_with_call: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE2
    $rose(call_request) |-> data_terminal_ready_line)
    else $error("terminal ready missing at call start");
  a_start_refused: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE1
    (cur_reg.state == PAC_IDLE && !p_power) |=> !call_request)
    else $error("call request raised without power");
  a_hangup_drop: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE22
    (reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CTRL_HANGUP] && cur_reg.state != PAC_IDLE &&
     cur_reg.state != PAC_RELEASE) |=> (!call_request && !data_terminal_ready_line))
    else $error("hangup left a line up");
  a_drop_online: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE21
    (cur_reg.state == PAC_ONLINE && cur_reg.drop_callreq) |=> !call_request)
    else $error("call request kept after drop order");
  a_end_after_last: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE10
    (cur_reg.state == PAC_WAIT_REQ && p_ndr && cur_reg.sent_last) |=> digit_lines == END_OF_NUMBER_CODE)
    else $error("end code not presented after last digit");
  a_strobe_release: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE8
    (cur_reg.state == PAC_STROBE && !p_ndr) |=> !digit_present_strobe)
    else $error("strobe kept after digit request fell");
  a_abandon_dtr: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE22
    (p_abandon && cur_reg.state != PAC_IDLE) |=> !data_terminal_ready_line)
    else $error("terminal ready kept after abandon");
  a_rts_mode: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE3
    $rose(call_request) |-> request_to_send_line == cur_reg.send_first)
    else $error("request to send does not follow send-first order");
endmodule : pac_originate

// ---- pac_pkg.sv ----
/*
 Package for the parallel autocall originating controller: command register
 map, status fields, digit codes and timing counts.
 Assumes a 40 MHz ref_clk and a modem that follows the parallel call handshake.
*/
package pac_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  // Register map of the controller itself (word addresses)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_DIGIT = 4'h2;
  localparam logic [3:0] ADDR_LINES = 4'h3;
  // Control bits
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_HANGUP = 1;
  localparam int unsigned CTRL_SEND_FIRST = 2;
  localparam int unsigned CTRL_DROP_CALLREQ = 3;
  // Status bits
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_DIGIT_READY = 1;
  localparam int unsigned ST_CONNECTED = 2;
  localparam int unsigned ST_ABANDONED = 3;
  localparam int unsigned ST_NOT_READY = 4;
  localparam int unsigned ST_STATE_LSB = 8;
  // Digit codes: digit write bit 4 marks the last digit of the number
  localparam logic [3:0] END_OF_NUMBER_CODE = 4'hc;
  localparam logic [3:0] SEPARATOR_CODE = 4'hd;
  localparam int unsigned DIGIT_LAST_BIT = 4;
  // Settling time of the digit lines before the strobe
  localparam int unsigned SETUP_NS = 100;
  localparam int unsigned SETUP_CYC = (SETUP_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [7:0] SETUP_CNT = 8'(SETUP_CYC);
  localparam logic [31:0] ST_RESET = 32'h0;
endpackage : pac_pkg

// ---- pac_modem_model.sv ----
/*
 Behavioural modem for the calling side: dials logged digits, answers or abandons.
 Assumes pac_originate drives the terminal pins from the same ref_clk.
*/
`timescale 1ns/1ps
module pac_modem_model
  import pac_pkg::*;
#(
  parameter int NO_ANS = 400,
  // Duplex modem without request to send
  parameter bit DUPLEX = 1'b0
)
(
  // Clock, reset, scenario knobs
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic power_on,
  input wire logic answer,
  input wire logic [31:0] lag,
  // Terminal pins
  input wire logic call_request,
  input wire logic [3:0] digit_lines,
  input wire logic digit_present_strobe,
  input wire logic data_terminal_ready_line,
  input wire logic request_to_send_line,
  // Modem pins
  output logic power_indication,
  output logic line_occupied,
  output logic next_digit_request,
  output logic abandon_call,
  output logic distant_connected,
  output logic data_set_ready_line,
  output logic ready_for_sending_line,
  output logic received_line_signal_detect,
  // Observation
  output logic viol,
  output logic [3:0] dialled [8],
  output int ndial
);
  int st;
  int cnt;
  logic [3:0] last_dl;
  logic last_stb;
  // Calling tone on the line, burst timing scaled down to clock cycles
  logic tone;
  assign power_indication = power_on;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st <= 0;
      cnt <= 0;
      viol <= 1'b0;
      ndial <= 0;
      last_dl <= 4'h0;
      last_stb <= 1'b0;
      tone <= 1'b0;
      {line_occupied, next_digit_request, abandon_call, distant_connected} <= 4'h0;
      {data_set_ready_line, ready_for_sending_line, received_line_signal_detect} <= 3'h0;
    end else begin
      last_dl <= digit_lines;
      last_stb <= digit_present_strobe;
      cnt <= cnt + 1;
      if (digit_present_strobe && last_stb && digit_lines !== last_dl) viol <= 1'b1;
      if (digit_present_strobe && !last_stb && (!next_digit_request || digit_lines !== last_dl)) viol <= 1'b1;
      if (!digit_present_strobe && last_stb && next_digit_request) viol <= 1'b1;
      case (st)
        0: begin
          tone <= 1'b0;
          {line_occupied, next_digit_request, abandon_call, distant_connected} <= 4'h0;
          {data_set_ready_line, ready_for_sending_line, received_line_signal_detect} <= 3'h0;
          if (call_request) begin
            st <= 1;
            cnt <= 0;
            ndial <= 0;
          end
        end
        1: if (cnt >= lag) begin
          line_occupied <= 1'b1;
          next_digit_request <= 1'b1;
          st <= 2;
          cnt <= 0;
        end
        2: if (digit_present_strobe && cnt >= lag) begin
          dialled[ndial[2:0]] <= digit_lines;
          ndial <= ndial + 1;
          next_digit_request <= 1'b0;
          st <= (digit_lines == END_OF_NUMBER_CODE) ? 4 : 3;
          cnt <= 0;
        end
        // No re-request until the strobe is gone
        3: if (!digit_present_strobe) begin
          next_digit_request <= 1'b1;
          st <= 2;
          cnt <= 0;
        end
        // Answer tone phase keeps receive indications low; answer heard in a tone gap
        4: begin
          tone <= (cnt % 32) < 8;
          if (answer && cnt >= lag * 20 && !tone) begin
            // Calling response is optional and not sent
            tone <= 1'b0;
            data_set_ready_line <= 1'b1;
            st <= 5;
            cnt <= 0;
          end else if (!answer && cnt == NO_ANS) begin
            tone <= 1'b0;
            abandon_call <= 1'b1;
            st <= 7;
          end
        end
        5: if (cnt >= lag) begin
          ready_for_sending_line <= DUPLEX || request_to_send_line;
          received_line_signal_detect <= DUPLEX || !request_to_send_line;
          distant_connected <= 1'b1;
          st <= 6;
        end
        6: if (!data_terminal_ready_line) st <= 0;
        default: if (!call_request) st <= 0;
      endcase
      if (st > 0 && st < 5 && !call_request) st <= 0;
    end
  end
endmodule : pac_modem_model

// ---- test_pac_originate.sv ----
/*
 Self-checking bench for pac_originate against the behavioural modem.
 Assumes the register map and codes of pac_pkg.
*/
`timescale 1ns/1ps
module test_pac_originate;
  import pac_pkg::*;
  logic ref_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, power_on = 1, answer = 1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic call_request, digit_present_strobe, data_terminal_ready_line, request_to_send_line;
  logic power_indication, line_occupied, next_digit_request, abandon_call, distant_connected;
  logic data_set_ready_line, ready_for_sending_line, received_line_signal_detect, viol;
  logic [3:0] digit_lines;
  logic [3:0] dialled [8];
  logic [3:0] codes [4] = '{4'h1, 4'h8, SEPARATOR_CODE, 4'h0};
  int lag = 3, ndial, miscompares = 0, num_checks = 0;
  always #12.5 ref_clk = ~ref_clk;
  pac_originate pac_originate_inst (.*);
  pac_modem_model pac_modem_model_inst (.*);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge ref_clk) reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge ref_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk) reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task poll(input int b);
    int k;
    k = 0;
    d = 0;
    while (d[b] !== 1'b1 && k < 3000) begin
      rd(ADDR_STATUS, d);
      k++;
    end
    chk({31'h0, d[b]}, 32'h1);
  endtask : poll
  task pins(input logic [2:0] e);
    @(posedge ref_clk) #1;
    chk({29'h0, call_request, data_terminal_ready_line, request_to_send_line}, {29'h0, e});
  endtask : pins
  task dial(input int n);
    for (int i = 0; i < n; i++) begin
      poll(ST_DIGIT_READY);
      wr(ADDR_DIGIT, {27'h0, 1'(i == n - 1), codes[i]});
    end
  endtask : dial
  task tally_and_finish;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // Whole run needs well under 20000 cycles
  initial begin
    #(25 * 60000);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    pins(3'b000);
    rd(ADDR_LINES, d);
    chk(d, 32'h1);
    power_on <= 1'b0;
    repeat (6) @(posedge ref_clk);
    wr(ADDR_CTRL, 32'h1 << CTRL_START);
    pins(3'b000);
    rd(ADDR_STATUS, d);
    chk({31'h0, d[ST_NOT_READY]}, 32'h1);
    power_on <= 1'b1;
    repeat (6) @(posedge ref_clk);
    wr(ADDR_CTRL, (32'h1 << CTRL_START) | (32'h1 << CTRL_SEND_FIRST));
    pins(3'b111);
    dial(4);
    poll(ST_CONNECTED);
    rd(ADDR_LINES, d);
    chk(d, 32'h73);
    chk(32'(ndial), 32'h5);
    for (int i = 0; i < 4; i++) chk({28'h0, dialled[i]}, {28'h0, codes[i]});
    chk({28'h0, dialled[4]}, {28'h0, END_OF_NUMBER_CODE});
    chk({31'h0, viol}, 32'h0);
    wr(ADDR_CTRL, (32'h1 << CTRL_SEND_FIRST) | (32'h1 << CTRL_DROP_CALLREQ));
    pins(3'b011);
    wr(ADDR_CTRL, 32'h1 << CTRL_HANGUP);
    pins(3'b000);
    answer <= 1'b0;
    lag <= 9;
    repeat (8) @(posedge ref_clk);
    wr(ADDR_CTRL, 32'h1 << CTRL_START);
    pins(3'b110);
    dial(2);
    poll(ST_ABANDONED);
    repeat (2) @(posedge ref_clk);
    pins(3'b000);
    chk({31'h0, viol}, 32'h0);
    tally_and_finish();
  end
endmodule : test_pac_originate
